// ==== rtl/gauge_policy.sv ====
// Gauge switching, unit, analog mode and fault relay policy with Wishbone registers
// How it works
// - Switch gauge off above deactivation limit
// - Off limit defaults 6.0E-3, not below on
// - Off limit used only for listed sources
// - Channel-sourced gauge on below on limit
// - Seven units, Torr and micron lockable
// - Four analog outputs share one mode
// - Relay on all, unit, or channel errors
// - Policy off: underrange valid, switching on
// - Policy on: underrange valid, switching off
// - Policy on: ten second suppression windows
// - Slow underrange transition may briefly switch
`timescale 1ns/10ps
`default_nettype none
module gauge_policy (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [63:0] chPressure,
   input  wire logic [3:0]  chUnderrange,
   input  wire logic [3:0]  chError,
   input  wire logic        unitError,
   input  wire logic        torrLock,
   output logic      [3:0]  gaugeEnable,
   output logic      [3:0]  switchActive,
   output logic      [3:0]  belowRangeIndication,
   output logic      [1:0]  analogMode,
   output logic      [2:0]  unitSel,
   output logic             faultRelay
);
   localparam int N = gauge_policy_pkg::NUM_CH;
   localparam int W = gauge_policy_pkg::PRESS_W;

   // Pin synchronisers
   logic [63:0] pressS1_reg, pressS2_reg, pressS3_reg, press_reg;
   logic [3:0]  urS1_reg, ur_reg, errS1_reg, err_reg;
   logic        unitErrS1_reg, unitErr_reg, lockS1_reg, lock_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pressS1_reg   <= '0;
         pressS2_reg   <= '0;
         pressS3_reg   <= '0;
         press_reg     <= '0;
         urS1_reg      <= '0;
         ur_reg        <= '0;
         errS1_reg     <= '0;
         err_reg       <= '0;
         unitErrS1_reg <= 1'b0;
         unitErr_reg   <= 1'b0;
         lockS1_reg    <= 1'b0;
         lock_reg      <= 1'b0;
      end else begin
         pressS1_reg   <= chPressure;
         pressS2_reg   <= pressS1_reg;
         pressS3_reg   <= pressS2_reg;
         // Word taken only once two synced samples agree
         if (pressS2_reg == pressS3_reg)
            press_reg  <= pressS2_reg;
         urS1_reg      <= chUnderrange;
         ur_reg        <= urS1_reg;
         errS1_reg     <= chError;
         err_reg       <= errS1_reg;
         unitErrS1_reg <= unitError;
         unitErr_reg   <= unitErrS1_reg;
         lockS1_reg    <= torrLock;
         lock_reg      <= lockS1_reg;
      end
   end

   // Configuration registers
   gauge_policy_pkg::unit_e  unit_reg;
   gauge_policy_pkg::aout_e  aout_reg;
   gauge_policy_pkg::relay_e relay_reg;
   logic                     urPolicy_reg;
   gauge_policy_pkg::src_e   src_reg   [N];
   logic [W-1:0]             onLim_reg [N];
   logic [W-1:0]             offLim_reg[N];
   logic [N-1:0]             manOn_reg;
   logic [N-1:0]             gate_reg;

   logic       wrStb;
   logic [1:0] chIdx;
   logic       chHit;
   logic [7:0] chOff;
   assign wrStb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   assign chHit = (wb_adr_i >= gauge_policy_pkg::ADDR_CH_BASE) && (wb_adr_i < 8'h50);
   assign chIdx = wb_adr_i[5:4] - 2'h1;
   assign chOff = {4'h0, wb_adr_i[3:0]};

   logic [W-1:0] newOn, newOff;
   assign newOn  = wb_dat_i[gauge_policy_pkg::LIM_ON_LSB +: W];
   assign newOff = wb_dat_i[gauge_policy_pkg::LIM_OFF_LSB +: W];

   function automatic logic unitLegal(input logic [2:0] u, input logic lk);
      logic torrish;
      torrish = (u == gauge_policy_pkg::UNIT_TORR) || (u == gauge_policy_pkg::UNIT_MICRON);
      return (u <= gauge_policy_pkg::UNIT_AMP) && !(torrish && lk);
   endfunction

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         unit_reg     <= gauge_policy_pkg::UNIT_MBAR;
         aout_reg     <= gauge_policy_pkg::AOUT_OFF;
         relay_reg    <= gauge_policy_pkg::RELAY_ALL;
         urPolicy_reg <= 1'b0;
      end else begin
         if (wrStb && wb_adr_i == gauge_policy_pkg::ADDR_GEN && wb_sel_i[0] &&
             unitLegal(wb_dat_i[gauge_policy_pkg::GEN_UNIT_LSB +: 3], lock_reg))
            unit_reg <= gauge_policy_pkg::unit_e'(wb_dat_i[gauge_policy_pkg::GEN_UNIT_LSB +: 3]);
         else if (lock_reg && (unit_reg == gauge_policy_pkg::UNIT_TORR ||
                  unit_reg == gauge_policy_pkg::UNIT_MICRON))
            unit_reg <= gauge_policy_pkg::UNIT_MBAR;
         if (wrStb && wb_adr_i == gauge_policy_pkg::ADDR_GEN && wb_sel_i[0])
            aout_reg <= gauge_policy_pkg::aout_e'(wb_dat_i[gauge_policy_pkg::GEN_AOUT_LSB +: 2]);
         if (wrStb && wb_adr_i == gauge_policy_pkg::ADDR_GEN && wb_sel_i[1]) begin
            if (wb_dat_i[gauge_policy_pkg::GEN_RELAY_LSB +: 3] <= 3'(gauge_policy_pkg::RELAY_CH3))
               relay_reg <= gauge_policy_pkg::relay_e'(wb_dat_i[gauge_policy_pkg::GEN_RELAY_LSB +: 3]);
            urPolicy_reg <= wb_dat_i[gauge_policy_pkg::GEN_UR_POL_BIT];
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < N; i++) begin
            src_reg[i]    <= gauge_policy_pkg::SRC_HAND;
            onLim_reg[i]  <= gauge_policy_pkg::ON_LIMIT_RST;
            offLim_reg[i] <= gauge_policy_pkg::OFF_LIMIT_RST;
            manOn_reg[i]  <= 1'b0;
         end
      end else if (wrStb && chHit) begin
         if (chOff == gauge_policy_pkg::ADDR_CH_CTRL && wb_sel_i[0]) begin
            if (wb_dat_i[3:0] <= 4'(gauge_policy_pkg::SRC_HOT_CH3))
               src_reg[chIdx] <= gauge_policy_pkg::src_e'(wb_dat_i[3:0]);
            manOn_reg[chIdx] <= wb_dat_i[gauge_policy_pkg::CTL_ON_BIT];
         end
         // Ordering off >= on enforced; violating writes ignored
         if (chOff == gauge_policy_pkg::ADDR_CH_LIM && wb_sel_i == 4'hf && newOff >= newOn) begin
            onLim_reg[chIdx]  <= newOn;
            offLim_reg[chIdx] <= newOff;
         end
      end
   end

   // Suppression timers, one per channel
   logic [N-1:0] suppressed;
   generate
      for (genvar g = 0; g < N; g++) begin : g_sup
         suppress_if sif ();
         assign sif.gaugeOn    = gate_reg[g];
         assign sif.underrange = ur_reg[g];
         assign sif.policyEn   = urPolicy_reg;
         assign suppressed[g]  = sif.suppressed;
         suppress_timer suppress_timer_i (
            .clk    (clk),
            .arst_n (arst_n),
            .sup    (sif.timer)
         );
      end
   endgenerate

   // Gauge on/off decision with hysteresis
   logic [N-1:0] gate_next;
   always_comb begin
      gate_next = gate_reg;
      for (int i = 0; i < N; i++) begin
         logic [3:0]   s;
         logic [1:0]   refCh;
         logic [W-1:0] p;
         logic         offEval;
         logic         onEval;
         s       = 4'(src_reg[i]);
         refCh   = '0;
         p       = '0;
         offEval = 1'b0;
         onEval  = 1'b0;
         if (s == 4'(gauge_policy_pkg::SRC_SELF)) begin
            refCh   = 2'(i);
            offEval = 1'b1;
         end else if (s >= 4'(gauge_policy_pkg::SRC_CH0) && s <= 4'(gauge_policy_pkg::SRC_CH3)) begin
            refCh   = 2'(s - 4'(gauge_policy_pkg::SRC_CH0));
            offEval = 1'b1;
            onEval  = (refCh != 2'(i));
         end else if (s >= 4'(gauge_policy_pkg::SRC_HOT_CH0)) begin
            refCh   = 2'(s - 4'(gauge_policy_pkg::SRC_HOT_CH0));
            offEval = 1'b1;
            onEval  = (refCh != 2'(i));
         end
         p = press_reg[refCh*W +: W];
         if (!offEval && !onEval) begin
            gate_next[i] = manOn_reg[i];
         end else if (offEval && p > offLim_reg[i]) begin
            gate_next[i] = 1'b0;
         end else if (onEval && p < onLim_reg[i]) begin
            gate_next[i] = 1'b1;
         end else if (!onEval && manOn_reg[i] && !gate_reg[i] && p <= offLim_reg[i]) begin
            gate_next[i] = 1'b1;
         end
         // Otherwise the gauge keeps its state
      end
   end

   logic [N-1:0] hotStart_reg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gate_reg     <= '0;
         hotStart_reg <= '1;
      end else begin
         hotStart_reg <= '0;
         for (int i = 0; i < N; i++) begin
            if (hotStart_reg[i] && src_reg[i] >= gauge_policy_pkg::SRC_HOT_CH0)
               gate_reg[i] <= 1'b1;
            else
               gate_reg[i] <= gate_next[i];
         end
      end
   end

   // Switching function gated by underrange policy; a slow overrange-to-underrange
   // transition may leave it briefly on after suppression ends
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         switchActive         <= '0;
         belowRangeIndication <= '0;
      end else begin
         belowRangeIndication <= ur_reg;
         for (int i = 0; i < N; i++) begin
            if (!urPolicy_reg)
               switchActive[i] <= gate_reg[i];
            else
               switchActive[i] <= gate_reg[i] & ~ur_reg[i] & ~suppressed[i];
         end
      end
   end

   // Fault relay selection
   logic relayNext;
   always_comb begin
      unique case (relay_reg)
         gauge_policy_pkg::RELAY_ALL:  relayNext = unitErr_reg | (|err_reg);
         gauge_policy_pkg::RELAY_UNIT: relayNext = unitErr_reg;
         default: relayNext = unitErr_reg |
                              err_reg[2'(3'(relay_reg) - 3'(gauge_policy_pkg::RELAY_CH0))];
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         faultRelay <= 1'b0;
      else
         faultRelay <= relayNext;
   end

   assign gaugeEnable = gate_reg;
   assign analogMode  = aout_reg;
   assign unitSel     = unit_reg;

   // Wishbone read and ack
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         wb_dat_o <= '0;
         if (wb_adr_i == gauge_policy_pkg::ADDR_GEN)
            wb_dat_o <= {15'h0, lock_reg, 3'h0, urPolicy_reg, 1'b0, relay_reg,
                         2'h0, aout_reg, 1'b0, unit_reg};
         else if (wb_adr_i == gauge_policy_pkg::ADDR_STATUS)
            wb_dat_o <= {11'h0, unitErr_reg, err_reg, ur_reg, suppressed, switchActive, gate_reg};
         else if (chHit && chOff == gauge_policy_pkg::ADDR_CH_CTRL)
            wb_dat_o <= {27'h0, manOn_reg[chIdx], 4'(src_reg[chIdx])};
         else if (chHit && chOff == gauge_policy_pkg::ADDR_CH_LIM)
            wb_dat_o <= {offLim_reg[chIdx], onLim_reg[chIdx]};
         else if (chHit && chOff == gauge_policy_pkg::ADDR_CH_PRESS)
            wb_dat_o <= {16'h0, press_reg[chIdx*W +: W]};
      end
   end

   a_limit_order: assert property (@(posedge clk) disable iff (!arst_n)
      offLim_reg[0] >= onLim_reg[0])
      else $error("Off limit below on limit");
   a_ur_hold_off: assert property (@(posedge clk) disable iff (!arst_n)
      (urPolicy_reg && ur_reg[3]) |=> !switchActive[3])
      else $error("Switching on during underrange with policy");
   a_ur_keep_on: assert property (@(posedge clk) disable iff (!arst_n)
      (!urPolicy_reg && gate_reg[1]) |=> switchActive[1])
      else $error("Switching off with policy disabled");
   a_torr_lock: assert property (@(posedge clk) disable iff (!arst_n)
      $past(lock_reg) && lock_reg |-> unit_reg != gauge_policy_pkg::UNIT_TORR)
      else $error("Torr selected under lock");
   a_relay_all: assert property (@(posedge clk) disable iff (!arst_n)
      (relay_reg == gauge_policy_pkg::RELAY_ALL && |err_reg) |=> faultRelay)
      else $error("Relay missed channel error");
   a_relay_unit: assert property (@(posedge clk) disable iff (!arst_n)
      (relay_reg == gauge_policy_pkg::RELAY_UNIT && !unitErr_reg) |=> !faultRelay)
      else $error("Relay on without unit error");
   a_off_above: assert property (@(posedge clk) disable iff (!arst_n)
      (src_reg[0] == gauge_policy_pkg::SRC_SELF && press_reg[15:0] > offLim_reg[0]
       && !hotStart_reg[0]) |=> !gate_reg[0])
      else $error("Gauge not switched off above limit");
   a_hand_no_eval: assert property (@(posedge clk) disable iff (!arst_n)
      (src_reg[2] == gauge_policy_pkg::SRC_HAND && !hotStart_reg[2])
      |=> gate_reg[2] == $past(manOn_reg[2]))
      else $error("Hand source evaluated against limit");
   a_on_below: assert property (@(posedge clk) disable iff (!arst_n)
      (src_reg[1] == gauge_policy_pkg::SRC_CH0 && press_reg[15:0] < onLim_reg[1])
      |=> gate_reg[1])
      else $error("Gauge not switched on below limit");
   a_hysteresis: assert property (@(posedge clk) disable iff (!arst_n)
      (src_reg[1] == gauge_policy_pkg::SRC_CH0 && !hotStart_reg[1] &&
       press_reg[15:0] >= onLim_reg[1] && press_reg[15:0] <= offLim_reg[1])
      |=> gate_reg[1] == $past(gate_reg[1]))
      else $error("Gauge state changed inside hysteresis band");
   a_analog_mode: assert property (@(posedge clk) disable iff (!arst_n)
      analogMode == 2'(aout_reg))
      else $error("Analog mode output mismatch");

   c_gauge_off: cover property (@(posedge clk) disable iff (!arst_n) $fell(gate_reg[0]));
   c_gauge_on: cover property (@(posedge clk) disable iff (!arst_n) $rose(gate_reg[1]));
   c_suppress: cover property (@(posedge clk) disable iff (!arst_n) $rose(suppressed[3]));
   c_relay: cover property (@(posedge clk) disable iff (!arst_n) $rose(faultRelay));
endmodule
`default_nettype wire

// ==== rtl/gauge_policy_pkg.sv ====
// Constants, register map and encodings for the gauge switching policy block
package gauge_policy_pkg;
   localparam int          NUM_CH          = 4;
   localparam int          PRESS_W         = 16;
   // Pressure codes: monotonic log-scale word, larger means higher pressure
   localparam logic [15:0] OFF_LIMIT_RST   = 16'h6003; // 6.0E-3 default
   localparam logic [15:0] ON_LIMIT_RST    = 16'h5003; // 5.0E-3 default
   localparam int          CLK_HZ          = 20_000_000;
   localparam int          SUPPRESS_S      = 10;
   localparam int          SUPPRESS_CYC    = SUPPRESS_S * CLK_HZ;
   localparam int          TMR_W           = 28;
   // Register byte addresses
   localparam logic [7:0]  ADDR_GEN        = 8'h00;
   localparam logic [7:0]  ADDR_STATUS     = 8'h04;
   localparam logic [7:0]  ADDR_CH_BASE    = 8'h10; // +0x10 per channel
   localparam logic [7:0]  ADDR_CH_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_CH_LIM     = 8'h04;
   localparam logic [7:0]  ADDR_CH_PRESS   = 8'h08;
   // General register fields
   localparam int          GEN_UNIT_LSB    = 0;
   localparam int          GEN_AOUT_LSB    = 4;
   localparam int          GEN_RELAY_LSB   = 8;
   localparam int          GEN_UR_POL_BIT  = 12;
   localparam int          GEN_LOCK_BIT    = 16;
   // Channel control fields
   localparam int          CTL_SRC_LSB     = 0;
   localparam int          CTL_ON_BIT      = 4;
   // Limit register fields
   localparam int          LIM_ON_LSB      = 0;
   localparam int          LIM_OFF_LSB     = 16;

   typedef enum logic [2:0] {UNIT_HPA, UNIT_MBAR, UNIT_TORR, UNIT_PA, UNIT_MICRON,
                             UNIT_VOLT, UNIT_AMP} unit_e;
   typedef enum logic [1:0] {AOUT_OFF, AOUT_5V_DIRECT, AOUT_10V_FILT, AOUT_20MA_FILT} aout_e;
   typedef enum logic [2:0] {RELAY_ALL, RELAY_UNIT, RELAY_CH0, RELAY_CH1, RELAY_CH2,
                             RELAY_CH3} relay_e;
   typedef enum logic [3:0] {SRC_HAND, SRC_SELF, SRC_CH0, SRC_CH1, SRC_CH2, SRC_CH3,
                             SRC_HOT_CH0, SRC_HOT_CH1, SRC_HOT_CH2, SRC_HOT_CH3} src_e;
endpackage

// ==== rtl/suppress_if.sv ====
// Interface carrying one channel's suppression request and state
`timescale 1ns/10ps
`default_nettype none
interface suppress_if;
   logic gaugeOn;
   logic underrange;
   logic policyEn;
   logic suppressed;
   modport ctrl (output gaugeOn, output underrange, output policyEn, input suppressed);
   modport timer (input gaugeOn, input underrange, input policyEn, output suppressed);
endinterface
`default_nettype wire

// ==== rtl/suppress_timer.sv ====
// Per-channel ten second switching suppression timer
`timescale 1ns/10ps
`default_nettype none
module suppress_timer (
   input  wire logic     clk,
   input  wire logic     arst_n,
   suppress_if.timer     sup
);
   logic [gauge_policy_pkg::TMR_W-1:0] count_reg;
   logic                               onDly_reg;
   logic                               urDly_reg;
   logic                               restart;

   // Gauge turned on, or underrange newly recurring
   assign restart = (sup.gaugeOn & ~onDly_reg) | (sup.underrange & ~urDly_reg);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         onDly_reg <= 1'b0;
         urDly_reg <= 1'b0;
      end else begin
         onDly_reg <= sup.gaugeOn;
         urDly_reg <= sup.underrange;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count_reg <= '0;
      end else if (!sup.policyEn) begin
         count_reg <= '0;
      end else if (restart) begin
         count_reg <= gauge_policy_pkg::TMR_W'(gauge_policy_pkg::SUPPRESS_CYC);
      end else if (count_reg != '0) begin
         count_reg <= count_reg - 1'b1;
      end
   end

   assign sup.suppressed = (count_reg != '0);

   a_suppress_load: assert property (@(posedge clk) disable iff (!arst_n)
      (sup.policyEn && sup.gaugeOn && !onDly_reg) |=> sup.suppressed)
      else $error("Suppression did not start on gauge turn-on");
   a_suppress_off: assert property (@(posedge clk) disable iff (!arst_n)
      !sup.policyEn |=> !sup.suppressed)
      else $error("Suppression active with policy disabled");
endmodule
`default_nettype wire

// ==== tb/gauge_far_side.sv ====
// Far-side model: gauges and process control feeding the policy block
`timescale 1ns/10ps
`default_nettype none
module gauge_far_side (
   input  wire logic        clk,
   output logic      [63:0] chPressure,
   output logic      [3:0]  chUnderrange,
   output logic      [3:0]  chError,
   output logic             unitError,
   output logic             torrLock
);
   // Gauges start at atmosphere, healthy
   initial begin
      chPressure   = {4{16'hffff}};
      chUnderrange = 4'h0;
      chError      = 4'h0;
      unitError    = 1'b0;
      torrLock     = 1'b0;
   end

   task automatic set_press(input int ch, input logic [15:0] val);
      @(posedge clk);
      chPressure[ch*16 +: 16] <= val;
   endtask

   task automatic set_flags(input logic [3:0] ur, input logic [3:0] err, input logic uerr,
                            input logic lock);
      @(posedge clk);
      chUnderrange <= ur;
      chError      <= err;
      unitError    <= uerr;
      torrLock     <= lock;
   endtask
endmodule
`default_nettype wire

// ==== tb/gauge_policy_test.sv ====
// Self-checking bench for the gauge switching and relay policy block
`timescale 1ns/10ps
`default_nettype none
module gauge_policy_test;
   typedef struct packed {
      logic [31:0] gen;
      logic [2:0]  unit;
      logic [1:0]  aout;
   } row_s;
   localparam row_s ROWS [7] = '{'{32'h0000_0000, 3'h0, 2'h0}, '{32'h0000_0111, 3'h1, 2'h1},
      '{32'h0000_0222, 3'h2, 2'h2}, '{32'h0000_0333, 3'h3, 2'h3}, '{32'h0000_0404, 3'h4, 2'h0},
      '{32'h0000_0515, 3'h5, 2'h1}, '{32'h0000_0026, 3'h6, 2'h2}};

   logic        clk;
   logic        arst_n;
   logic        wbCyc;
   logic        wbStb;
   logic        wbWe;
   logic [7:0]  wbAdr;
   logic [3:0]  wbSel;
   logic [31:0] wbDatW;
   logic [31:0] wbDatR;
   logic        wbAck;
   logic [63:0] chPressure;
   logic [3:0]  chUnderrange;
   logic [3:0]  chError;
   logic        unitError;
   logic        torrLock;
   logic [3:0]  gaugeEnable;
   logic [3:0]  switchActive;
   logic [3:0]  belowRangeIndication;
   logic [1:0]  analogMode;
   logic [2:0]  unitSel;
   logic        faultRelay;
   int          errorCnt = 0;
   int          cmpCount = 0;

   gauge_policy gauge_policy_i (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
      .wb_ack_o(wbAck), .chPressure(chPressure), .chUnderrange(chUnderrange),
      .chError(chError), .unitError(unitError), .torrLock(torrLock),
      .gaugeEnable(gaugeEnable), .switchActive(switchActive),
      .belowRangeIndication(belowRangeIndication), .analogMode(analogMode),
      .unitSel(unitSel), .faultRelay(faultRelay));

   gauge_far_side gauge_far_side_i (.clk(clk), .chPressure(chPressure),
      .chUnderrange(chUnderrange), .chError(chError), .unitError(unitError),
      .torrLock(torrLock));

   always #25 clk = ~clk;

   task automatic wrap_up();
      if (errorCnt == 0 && cmpCount > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmpCount++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         errorCnt++;
      end
   endtask

   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
      int n;
      @(posedge clk);
      wbCyc  <= 1'b1;
      wbStb  <= 1'b1;
      wbWe   <= we;
      wbAdr  <= adr;
      wbDatW <= wd;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      rd = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe  <= 1'b0;
      if (wbAck !== 1'b1) begin
         $display("mismatch wb_ack expected 1 seen %b", wbAck);
         errorCnt++;
         wrap_up();
      end
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, adr, d, q);
   endtask

   task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] m);
      logic [31:0] q;
      wb(1'b0, adr, 32'h0000_0000, q);
      chk("read data", exp & m, q & m);
   endtask

   // Input sync plus decision latency
   task automatic settle();
      repeat (6) @(posedge clk);
   endtask

   task automatic relay_case(input logic [2:0] code, input logic [3:0] err, input logic uerr,
                             input logic exp);
      wr(gauge_policy_pkg::ADDR_GEN, {21'h000000, code, 8'h01});
      gauge_far_side_i.set_flags(4'h0, err, uerr, 1'b0);
      settle();
      chk("faultRelay", 32'(exp), 32'(faultRelay));
   endtask

   task automatic press_step(input logic [15:0] p, input logic exp);
      gauge_far_side_i.set_press(0, p);
      settle();
      chk("gaugeEnable1", 32'(exp), 32'(gaugeEnable[1]));
   endtask

   initial begin
      clk    = 1'b0;
      arst_n = 1'b0;
      wbCyc  = 1'b0;
      wbStb  = 1'b0;
      wbWe   = 1'b0;
      wbAdr  = 8'h00;
      wbSel  = 4'hf;
      wbDatW = 32'h0000_0000;
      repeat (5) @(posedge clk);
      chk("unitSel", 32'h1, 32'(unitSel));
      chk("analogMode", 32'h0, 32'(analogMode));
      chk("faultRelay", 32'h0, 32'(faultRelay));
      arst_n <= 1'b1;
      rdchk(gauge_policy_pkg::ADDR_GEN, 32'h0000_0001, 32'hffff_ffff);
      rdchk(8'h14, 32'h6003_5003, 32'hffff_ffff);
      wr(8'h0c, 32'hffff_ffff);
      rdchk(8'h0c, 32'h0000_0000, 32'hffff_ffff);
      foreach (ROWS[i]) begin
         wr(gauge_policy_pkg::ADDR_GEN, ROWS[i].gen);
         settle();
         chk("unitSel", 32'(ROWS[i].unit), 32'(unitSel));
         chk("analogMode", 32'(ROWS[i].aout), 32'(analogMode));
         rdchk(gauge_policy_pkg::ADDR_GEN, ROWS[i].gen, 32'h0000_1737);
      end
      relay_case(3'h1, 4'hf, 1'b0, 1'b0);
      relay_case(3'h1, 4'h0, 1'b1, 1'b1);
      relay_case(3'h4, 4'hb, 1'b0, 1'b0);
      relay_case(3'h4, 4'h4, 1'b0, 1'b1);
      relay_case(3'h0, 4'h1, 1'b0, 1'b1);
      relay_case(3'h0, 4'h0, 1'b0, 1'b0);
      // Torr lockout
      wr(gauge_policy_pkg::ADDR_GEN, 32'h0000_0002);
      gauge_far_side_i.set_flags(4'h0, 4'h0, 1'b0, 1'b1);
      settle();
      chk("unitSel", 32'h1, 32'(unitSel));
      wr(gauge_policy_pkg::ADDR_GEN, 32'h0000_0004);
      settle();
      chk("unitSel", 32'h1, 32'(unitSel));
      rdchk(gauge_policy_pkg::ADDR_GEN, 32'h0001_0001, 32'h0001_0007);
      wr(gauge_policy_pkg::ADDR_GEN, 32'h0000_0003);
      settle();
      chk("unitSel", 32'h3, 32'(unitSel));
      gauge_far_side_i.set_flags(4'h0, 4'h0, 1'b0, 1'b0);
      // Limits: off below on is refused, then a legal pair
      wr(8'h24, 32'h5000_6000);
      rdchk(8'h24, 32'h6003_5003, 32'hffff_ffff);
      wr(8'h24, 32'h7000_4000);
      rdchk(8'h24, 32'h7000_4000, 32'hffff_ffff);
      wr(8'h20, 32'h0000_0002);
      press_step(16'h7000, 1'b0);
      press_step(16'h4000, 1'b0);
      press_step(16'h3fff, 1'b1);
      press_step(16'h7000, 1'b1);
      press_step(16'h7001, 1'b0);
      press_step(16'h5000, 1'b0);
      // Self-controlled gauge on channel 0
      wr(8'h10, 32'h0000_0011);
      settle();
      chk("gaugeEnable0", 32'h1, 32'(gaugeEnable[0]));
      gauge_far_side_i.set_press(0, 16'h6004);
      settle();
      chk("gaugeEnable0", 32'h0, 32'(gaugeEnable[0]));
      // Manual gauge above off limit, then underrange handling
      wr(8'h40, 32'h0000_0010);
      settle();
      chk("gaugeEnable3", 32'h1, 32'(gaugeEnable[3]));
      gauge_far_side_i.set_flags(4'h8, 4'h0, 1'b0, 1'b0);
      settle();
      chk("switchActive3", 32'h1, 32'(switchActive[3]));
      chk("belowRange3", 32'h1, 32'(belowRangeIndication[3]));
      // Policy enabled only here, with the operator's consent
      wr(gauge_policy_pkg::ADDR_GEN, 32'h0000_1001);
      settle();
      chk("switchActive3", 32'h0, 32'(switchActive[3]));
      chk("belowRange3", 32'h1, 32'(belowRangeIndication[3]));
      gauge_far_side_i.set_flags(4'h0, 4'h0, 1'b0, 1'b0);
      gauge_far_side_i.set_flags(4'h8, 4'h0, 1'b0, 1'b0); // Underrange recurs
      gauge_far_side_i.set_flags(4'h0, 4'h0, 1'b0, 1'b0);
      settle();
      chk("switchActive3", 32'h0, 32'(switchActive[3]));
      rdchk(gauge_policy_pkg::ADDR_STATUS, 32'h0000_0800, 32'h0000_0800);
      // Gauge turned on while the policy is enabled
      wr(8'h30, 32'h0000_0010);
      settle();
      chk("gaugeEnable2", 32'h1, 32'(gaugeEnable[2]));
      chk("switchActive2", 32'h0, 32'(switchActive[2]));
      // Second reset in mid-run
      arst_n <= 1'b0;
      settle();
      chk("unitSel", 32'h1, 32'(unitSel));
      chk("gaugeEnable", 32'h0, 32'(gaugeEnable));
      arst_n <= 1'b1;
      rdchk(gauge_policy_pkg::ADDR_GEN, 32'h0000_0001, 32'hffff_ffff);
      rdchk(8'h24, 32'h6003_5003, 32'hffff_ffff);
      settle();
      chk("gaugeEnable", 32'h0, 32'(gaugeEnable));
      wrap_up();
   end
endmodule
`default_nettype wire
